// ### core/text_display_command_scroll.sv
// Purpose: Command execution, scrolling and page linking of a 16 by 64 text display.
// Assumes: Inputs synchronous to CLK; host keeps the strobe spacing.
// Notes: Frame timing arrives as line and frame start pulses.
`timescale 1ns/100ps
`include "cmd_exec_regs.svh"
module text_display_command_scroll
  import cmd_exec_pkg::*;
#(
  parameter int unsigned PAGE_ERASE_CYC = `CYC(`T_PAGE_ERASE_NS),
  parameter int unsigned EOL_ERASE_CYC = `CYC(`T_EOL_ERASE_NS),
  parameter int unsigned LINE_ERASE_CYC = `CYC(`T_LINE_ERASE_NS),
  parameter int unsigned SCROLL_CYC = `CYC(`T_SCROLL_NS),
  parameter int unsigned ASYNC_LONG_CYC = `CYC(`T_ASYNC_LONG_NS),
  parameter int unsigned ASYNC_SHORT_CYC = `CYC(`T_ASYNC_SHORT_NS),
  parameter int unsigned SYNC_CYC = `CYC(`T_SYNC_NS)
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic COMMAND_STROBE,
  input wire logic [2:0] COMMAND_CODE_INPUTS,
  input wire logic SYNC_MODE,
  input wire logic LINE_START,
  input wire logic FRAME_START,
  output logic BUSY,
  output logic WRITE_PULSE,
  output logic ERASE_PULSE,
  output logic [3:0] CURSOR_ROW,
  output logic [5:0] CURSOR_COL,
  output logic [3:0] TOP_LINE,
  output logic PAGE_SELECT,
  output logic SECOND_PAGE_FLAG,
  output logic END_OF_PAGE_PULSE_N
);
  busy_if bi ();
  exec_timer u_timer (
    .CLK(CLK),
    .RESET(RESET),
    .bi(bi)
  );

  function automatic logic [31:0] exec_cycles(input cmd_e c, input logic sync, input logic scr);
    logic [31:0] n;
    n = 32'(ASYNC_SHORT_CYC);
    case (c)
      CMD_PAGE_ERASE: n = 32'(PAGE_ERASE_CYC);
      CMD_EOL_ERASE: n = 32'(EOL_ERASE_CYC);
      CMD_LINE_ERASE: n = 32'(LINE_ERASE_CYC);
      CMD_LINE_FEED, CMD_CHAR: begin
        if (scr) begin
          n = 32'(SCROLL_CYC);
        end else if (sync) begin
          n = 32'(SYNC_CYC);
        end else begin
          n = 32'(ASYNC_LONG_CYC);
        end
      end
      default: n = sync ? 32'(SYNC_CYC) : 32'(ASYNC_SHORT_CYC);
    endcase
    return n;
  endfunction

  function automatic logic writes_memory(input cmd_e c, input logic scr);
    logic w;
    w = 1'b0;
    case (c)
      CMD_PAGE_ERASE, CMD_EOL_ERASE, CMD_LINE_ERASE, CMD_CHAR: w = 1'b1;
      CMD_LINE_FEED: w = scr;
      default: w = 1'b0;
    endcase
    return w;
  endfunction

  function automatic logic erases_memory(input cmd_e c, input logic scr);
    logic e;
    e = 1'b0;
    case (c)
      CMD_PAGE_ERASE, CMD_EOL_ERASE, CMD_LINE_ERASE: e = 1'b1;
      CMD_LINE_FEED, CMD_CHAR: e = scr;
      default: e = 1'b0;
    endcase
    return e;
  endfunction

  // True on displayed lines that already belong to the following page.
  function automatic logic in_next_page(input logic [3:0] line, input logic [3:0] scrolled);
    logic [4:0] first;
    first = {1'b0, `FRAME_LINES_MINUS1} + 5'h01 - {1'b0, scrolled};
    return ({1'b0, line} >= first);
  endfunction

  logic strobe_d_r;
  logic take;
  cmd_e cmd;
  logic scroll;
  logic at_bottom;
  logic at_last_col;
  logic [3:0] line_r;
  logic [3:0] pages_scrolled_r;
  logic page_gone_r;

  assign cmd = cmd_e'(COMMAND_CODE_INPUTS);
  assign take = COMMAND_STROBE && !strobe_d_r && !bi.busy;
  assign at_bottom = (CURSOR_ROW == `LAST_ROW);
  assign at_last_col = (CURSOR_COL == `LAST_COL);
  assign scroll = take && at_bottom &&
    ((cmd == CMD_LINE_FEED) || ((cmd == CMD_CHAR) && at_last_col));
  assign bi.load = take;
  assign bi.count = exec_cycles(cmd, SYNC_MODE, scroll);
  assign BUSY = bi.busy;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= COMMAND_STROBE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      CURSOR_ROW <= 4'h0;
      CURSOR_COL <= 6'h00;
    end else if (take) begin
      case (cmd)
        CMD_PAGE_ERASE: begin
          CURSOR_ROW <= 4'h0;
          CURSOR_COL <= 6'h00;
        end
        CMD_EOL_ERASE: CURSOR_COL <= 6'h00;
        CMD_LINE_FEED: begin
          if (!scroll) begin
            CURSOR_ROW <= CURSOR_ROW + 4'h1;
          end
        end
        CMD_CURSOR_LEFT: CURSOR_COL <= CURSOR_COL - 6'h01;
        CMD_CURSOR_UP: CURSOR_ROW <= CURSOR_ROW - 4'h1;
        CMD_CHAR: begin
          CURSOR_COL <= CURSOR_COL + 6'h01;
          if (at_last_col && !scroll) begin
            CURSOR_ROW <= CURSOR_ROW + 4'h1;
          end
        end
        default: CURSOR_ROW <= CURSOR_ROW;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      WRITE_PULSE <= 1'b0;
      ERASE_PULSE <= 1'b0;
    end else begin
      WRITE_PULSE <= take && writes_memory(cmd, scroll);
      ERASE_PULSE <= take && erases_memory(cmd, scroll);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      TOP_LINE <= 4'h0;
    end else if (take && cmd == CMD_PAGE_ERASE) begin
      TOP_LINE <= 4'h0;
    end else if (scroll) begin
      TOP_LINE <= TOP_LINE + 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pages_scrolled_r <= 4'h0;
      page_gone_r <= 1'b0;
      END_OF_PAGE_PULSE_N <= 1'b1;
    end else begin
      END_OF_PAGE_PULSE_N <= 1'b1;
      if (take && cmd == CMD_PAGE_ERASE) begin
        pages_scrolled_r <= 4'h0;
        page_gone_r <= 1'b0;
      end else if (scroll) begin
        pages_scrolled_r <= pages_scrolled_r + 4'h1;
        page_gone_r <= 1'b0;
        if (pages_scrolled_r == `FRAME_LINES_MINUS1) begin
          END_OF_PAGE_PULSE_N <= 1'b0;
          page_gone_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      line_r <= 4'h0;
    end else if (FRAME_START) begin
      line_r <= 4'h0;
    end else if (LINE_START) begin
      line_r <= line_r + 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PAGE_SELECT <= 1'b0;
      SECOND_PAGE_FLAG <= 1'b0;
    end else if (page_gone_r || pages_scrolled_r == 4'h0) begin
      PAGE_SELECT <= 1'b0;
      SECOND_PAGE_FLAG <= 1'b0;
    end else begin
      PAGE_SELECT <= in_next_page(line_r, pages_scrolled_r);
      SECOND_PAGE_FLAG <= in_next_page(line_r, pages_scrolled_r);
    end
  end
endmodule

// ### core/cmd_exec_regs.svh
// Purpose: Named constants for the command and scroll controller.
// Assumes: 200 MHz clock, period 5 ns.
// Notes: Times are in nanoseconds; cycle counts derive from them.
`ifndef CMD_EXEC_REGS_SVH
`define CMD_EXEC_REGS_SVH
`define CLK_PERIOD_NS 5
`define T_PAGE_ERASE_NS 132000000
`define T_EOL_ERASE_NS 4200000
`define T_LINE_ERASE_NS 8300000
`define T_SCROLL_NS 8300000
`define T_ASYNC_LONG_NS 130000
`define T_ASYNC_SHORT_NS 80000
`define T_SYNC_NS 64000
`define CYC(ns) ((ns) / `CLK_PERIOD_NS)
`define LAST_ROW 4'hF
`define LAST_COL 6'h3F
`define FRAME_LINES_MINUS1 4'hF
`endif

// ### core/cmd_exec_pkg.sv
// Purpose: Types shared by the command and scroll controller.
// Assumes: Three-bit command codes.
// Notes: Encodings follow the command table.
package cmd_exec_pkg;
  typedef enum logic [2:0] {
    CMD_PAGE_ERASE = 3'h0,
    CMD_EOL_ERASE = 3'h1,
    CMD_LINE_FEED = 3'h2,
    CMD_NOP = 3'h3,
    CMD_CURSOR_LEFT = 3'h4,
    CMD_LINE_ERASE = 3'h5,
    CMD_CURSOR_UP = 3'h6,
    CMD_CHAR = 3'h7
  } cmd_e;
endpackage

// ### core/busy_if.sv
// Purpose: Carries a load request and count to the execution timer and its busy state back.
// Assumes: One clock domain.
// Notes: The timer counts down the loaded cycle count.
`timescale 1ns/100ps
interface busy_if;
  logic load;
  logic [31:0] count;
  logic busy;
  logic done;
  modport ctrl (output load, output count, input busy, input done);
  modport timer (input load, input count, output busy, output done);
endinterface

// ### core/exec_timer.sv
// Purpose: Down counter that spans the execution time of a command.
// Assumes: Load and count are valid in the same cycle.
// Notes: Done pulses for one cycle as the count expires.
`timescale 1ns/100ps
module exec_timer (
  input wire logic CLK,
  input wire logic RESET,
  busy_if.timer bi
);
  logic [31:0] cnt_r;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_r <= 32'h0000_0000;
    end else if (bi.load) begin
      cnt_r <= bi.count;
    end else if (cnt_r != 32'h0000_0000) begin
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end
  assign bi.busy = (cnt_r != 32'h0000_0000);
  assign bi.done = (cnt_r == 32'h0000_0001);
endmodule

// ### tb/cmd_scroll_sva.sv
// Purpose: Port checks of the command controller.
// Assumes: Bench cycle counts, sync short span of 6.
// Notes: Bound to the top module.
`timescale 1ns/100ps
module cmd_scroll_sva (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic COMMAND_STROBE,
  input wire logic [2:0] COMMAND_CODE_INPUTS,
  input wire logic SYNC_MODE,
  input wire logic BUSY,
  input wire logic WRITE_PULSE,
  input wire logic ERASE_PULSE,
  input wire logic [3:0] CURSOR_ROW,
  input wire logic [5:0] CURSOR_COL,
  input wire logic [3:0] TOP_LINE,
  input wire logic PAGE_SELECT,
  input wire logic SECOND_PAGE_FLAG,
  input wire logic END_OF_PAGE_PULSE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_busy_start: assert property ($rose(COMMAND_STROBE) && !BUSY |=> BUSY)
    else $error("busy missing");
  a_char_write: assert property ($rose(COMMAND_STROBE) && !BUSY &&
    COMMAND_CODE_INPUTS == 3'h7 |=> WRITE_PULSE) else $error("no write");
  a_page_home: assert property ($rose(COMMAND_STROBE) && !BUSY &&
    COMMAND_CODE_INPUTS == 3'h0 |=> ERASE_PULSE && CURSOR_ROW == 4'h0 && CURSOR_COL == 6'h00)
    else $error("no home");
  a_sync_span: assert property ($rose(COMMAND_STROBE) && !BUSY && SYNC_MODE &&
    COMMAND_CODE_INPUTS == 3'h3 |=> BUSY [*6] ##1 !BUSY) else $error("sync span");
  a_scroll_up: assert property ($rose(COMMAND_STROBE) && !BUSY &&
    COMMAND_CODE_INPUTS == 3'h2 && CURSOR_ROW == 4'hF
    |=> ERASE_PULSE && TOP_LINE == $past(TOP_LINE) + 4'h1) else $error("no scroll");
  a_char_scroll: assert property ($rose(COMMAND_STROBE) && !BUSY &&
    COMMAND_CODE_INPUTS == 3'h7 && CURSOR_ROW == 4'hF && CURSOR_COL == 6'h3F
    |=> ERASE_PULSE && TOP_LINE == $past(TOP_LINE) + 4'h1) else $error("no char scroll");
  a_pulse_once: assert property (WRITE_PULSE |=> !WRITE_PULSE) else $error("long write");
  a_eop_short: assert property ($fell(END_OF_PAGE_PULSE_N) |=> END_OF_PAGE_PULSE_N)
    else $error("long eop");
  a_flag_pair: assert property (PAGE_SELECT == SECOND_PAGE_FLAG) else $error("flags");
  a_busy_ignore: assert property (BUSY && $rose(COMMAND_STROBE)
    |=> $stable(CURSOR_COL) && $stable(CURSOR_ROW)) else $error("strobe taken while busy");
  a_gone_low: assert property (!END_OF_PAGE_PULSE_N
    |=> !PAGE_SELECT && !SECOND_PAGE_FLAG) else $error("page select after page gone");
endmodule
bind text_display_command_scroll cmd_scroll_sva i_sva (.*);

// ### tb/host_decoder_model.sv
// Purpose: Host with decoder that strobes command codes.
// Assumes: Bench raises req for one cycle per command, and once more while busy with code 1.
// Notes: Counts end of page pulses as a page counter.
`timescale 1ns/100ps
module host_decoder_model (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic req,
  input wire logic [2:0] op,
  input wire logic eop_n,
  input wire logic wr_pulse,
  input wire logic roll,
  output logic strobe,
  output logic [2:0] code,
  output logic [3:0] pages,
  output logic mem_we
);
  assign mem_we = wr_pulse && !roll;
  always @(posedge CLK) begin
    if (RESET) begin
      strobe <= 1'b0;
      code <= 3'h0;
      pages <= 4'h0;
    end else begin
      strobe <= req;
      code <= req ? op : ~code;
      if (!eop_n) pages <= pages + 4'h1;
    end
  end
endmodule

// ### tb/tb_text_display_command_scroll.sv
// Purpose: Self-checking bench of the command controller.
// Assumes: Shortened execution counts.
// Notes: A software model tracks cursor and top line.
`timescale 1ns/100ps
module tb_text_display_command_scroll;
  import cmd_exec_pkg::*;
  logic CLK = 0, LINE_START = 0, FRAME_START = 0, RESET, SYNC_MODE, req, roll, mem_we;
  logic [2:0] op, code_w;
  logic strobe_w, BUSY, WRITE_PULSE, ERASE_PULSE, PAGE_SELECT, SECOND_PAGE_FLAG, eop_n;
  logic [3:0] CURSOR_ROW, TOP_LINE, pages;
  logic [5:0] CURSOR_COL;
  logic [16:0] lfsr = 17'h1_153C;
  logic [2:0] tbl [5] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  int num_errors = 0, n_checks = 0, row = 0, col = 0, top = 0, n, cyc = 0, i, scrolls = 0;
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    LINE_START <= #1 (cyc % 4 == 0);
    FRAME_START <= #1 (cyc % 64 == 0);
  end
  host_decoder_model i_host (.CLK(CLK), .RESET(RESET), .req(req), .op(op), .eop_n(eop_n),
    .wr_pulse(WRITE_PULSE), .roll(roll), .strobe(strobe_w), .code(code_w), .pages(pages),
    .mem_we(mem_we));
  text_display_command_scroll #(.PAGE_ERASE_CYC(40), .EOL_ERASE_CYC(20), .LINE_ERASE_CYC(30),
    .SCROLL_CYC(25), .ASYNC_LONG_CYC(13), .ASYNC_SHORT_CYC(8), .SYNC_CYC(6)) i_dut (
    .CLK(CLK), .RESET(RESET), .COMMAND_STROBE(strobe_w), .COMMAND_CODE_INPUTS(code_w),
    .SYNC_MODE(SYNC_MODE), .LINE_START(LINE_START), .FRAME_START(FRAME_START), .BUSY(BUSY),
    .WRITE_PULSE(WRITE_PULSE), .ERASE_PULSE(ERASE_PULSE), .CURSOR_ROW(CURSOR_ROW),
    .CURSOR_COL(CURSOR_COL), .TOP_LINE(TOP_LINE), .PAGE_SELECT(PAGE_SELECT),
    .SECOND_PAGE_FLAG(SECOND_PAGE_FLAG), .END_OF_PAGE_PULSE_N(eop_n));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task check_page;
    int s;
    int j;
    s = scrolls % 16;
    while (cyc % 64 != 0) @(posedge CLK) #1;
    repeat (3) @(posedge CLK);
    #1;
    for (j = 0; j < 16; j++) begin
      chk(PAGE_SELECT, s != 0 && j >= 16 - s);
      chk(SECOND_PAGE_FLAG, s != 0 && j >= 16 - s);
      repeat (4) @(posedge CLK);
      #1;
    end
  endtask
  task run(input logic [2:0] c);
    int e;
    bit sc;
    logic wr;
    logic er;
    logic mw;
    sc = (c == 2 && row == 15) || (c == 7 && row == 15 && col == 63);
    e = c == 0 ? 40 : c == 1 ? 20 : c == 5 ? 30 : sc ? 25 : SYNC_MODE ? 6 : (c == 2 || c == 7)
      ? 13 : 8;
    @(posedge CLK) #1;
    op = c;
    req = 1;
    @(posedge CLK) #1;
    req = 0;
    for (n = 0; n < 9 && BUSY !== 1'b1; n++) @(posedge CLK) #1;
    wr = WRITE_PULSE;
    er = ERASE_PULSE;
    mw = mem_we;
    n = 0;
    while (BUSY === 1'b1 && n < 99) begin
      req = (n == 3 && c == 3'h1);
      @(posedge CLK) #1;
      n++;
    end
    req = 0;
    chk(n, e);
    chk(wr, c == 0 || c == 1 || c == 5 || c == 7 || sc);
    chk(er, c == 0 || c == 1 || c == 5 || sc);
    chk(mw, (c == 0 || c == 1 || c == 5 || c == 7 || sc) && !roll);
    if (sc) scrolls++;
    case (c)
      0: begin row = 0; col = 0; top = 0; scrolls = 0; end
      1: col = 0;
      2: if (row == 15) top = (top + 1) % 16; else row++;
      4: col = (col + 63) % 64;
      6: row = (row + 15) % 16;
      7: begin
        col = (col + 1) % 64;
        if (col == 0 && row == 15) top = (top + 1) % 16;
        else if (col == 0) row++;
      end
    endcase
    chk(CURSOR_ROW, row);
    chk(CURSOR_COL, col);
    chk(TOP_LINE, top);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    wrap_up;
  end
  initial begin
    RESET = 1'b1;
    SYNC_MODE = 1'b0;
    req = 1'b0;
    roll = 1'b0;
    op = 3'h3;
    repeat (5) @(posedge CLK);
    #1 RESET = 0;
    run(3'h0);
    repeat (15) run(3'h2);
    for (i = 0; i < 8; i++) begin
      roll = i[0];
      run(3'h2);
      run(3'h4);
      run(3'h7);
      if (i == 3) check_page;
    end
    roll = 1'b0;
    chk(pages, 1);
    check_page;
    run(3'h1);
    run(3'h5);
    run(3'h0);
    SYNC_MODE = 1;
    run(3'h3);
    run(3'h5);
    repeat (40) begin
      lfsr = lfsr_next(lfsr);
      SYNC_MODE = lfsr[3];
      roll = lfsr[5];
      run(tbl[lfsr % 5]);
    end
    wrap_up;
  end
endmodule
